/* File: rtl/fc_stim_inject.sv */
// Transmit alarm and error injection with receive qualification counters.
`default_nettype none
// Behaviour
// [R1] Selected alarm repeats until set to none.
// [R2] Link reset sends K28.5 D9.2 D31.5 D9.2.
// [R3] Link reset response sends K28.5 D21.1 D31.5 D9.2.
// [R4] Not operational sends K28.5 D21.2 D31.5 D5.2.
// [R5] Offline sends K28.5 D21.1 D10.4 D21.2.
// [R6] Receiver ready primitive once per error.
// [R7] Bit error inverts one payload bit.
// [R8] Symbol error sends an undecodable code group.
// [R9] No symbol errors at the fast rates.
// [R10] CRC error flips a CRC field bit.
// [R11] No CRC errors when frames lack CRC.
// [R12] Block errors only at the fast rates.
// [R13] Manual trigger injects one burst; off injects none.
// [R14] One burst every second.
// [R15] One burst every ten seconds.
// [R16] Rate modes: one burst per decade units.
// [R17] Lost frame bits add to pattern errors.
// [R18] Address filter matches IDs, control and type.
// [R19] Without address filter, control byte zero.
// [R20] Controller keeps frame size multiple of four.
// [R21] Full store stops or wraps, and logs.
// [R22] Auto start ties generator to measurement.
// [R23] Reset and clear empty counters, insertion off; clear leaves the insertion mode as set, only reset turns it off.
module fc_stim_inject
   import fc_stim_pkg::*;
#(
   parameter int SEC_CLKS   = SEC_CYCLES,
   parameter int RECORDS    = STORE_RECORDS,
   parameter int BURST_W    = 16
) (
   input  wire logic                       clk,          // 40 MHz clock.
   input  wire logic                       rst,          // Async reset.
   input  wire logic [7:0]                 addr,         // Register offset.
   input  wire logic [31:0]                wdata,        // Write data.
   input  wire logic                       wr,           // Write strobe.
   input  wire logic                       rd,           // Read strobe.
   output logic      [31:0]                rdata,        // Read data.
   input  wire logic                       gen_valid,    // Word slot valid.
   input  wire logic [31:0]                gen_data,     // Generated word.
   input  wire logic [3:0]                 gen_k,        // Control flags.
   input  wire logic                       gen_payload,  // Word is payload.
   input  wire logic                       gen_crc,      // Word is CRC.
   input  wire logic                       gen_idle,     // Word is fill.
   input  wire logic                       blk_tick,     // Block boundary.
   output logic                            tx_valid,     // Word out valid.
   output logic      [31:0]                tx_data,      // Word out.
   output logic      [3:0]                 tx_k,         // Control flags.
   output logic                            tx_code_bad,  // Lane 0 invalid.
   output logic                            tx_blk_bad,   // Corrupt block.
   output logic                            gen_run,      // Generator on.
   input  wire logic                       rx_frame,     // Frame header in.
   input  wire logic [23:0]                rx_sid,       // Source ID.
   input  wire logic [23:0]                rx_did,       // Destination ID.
   input  wire logic [7:0]                 rx_rctl,      // Routing control.
   input  wire logic [7:0]                 rx_ftype,     // Type field.
   input  wire logic [7:0]                 rx_bit_errs,  // Bit errors seen.
   input  wire logic                       rx_lost,      // Frame missed.
   input  wire logic [15:0]                rx_lost_bits, // Its pattern bits.
   input  wire logic                       store_wr,     // Record written.
   output logic [$clog2(RECORDS)-1:0]      store_addr,   // Next record.
   output logic                            meas_run,     // Measuring.
   output logic                            log_full      // Store full event.
);
   localparam int AW = $clog2(RECORDS);
   localparam logic [31:0] SEC_P = 32'(SEC_CLKS);
   localparam logic [31:0] SEC10_P = 32'(SEC_CLKS * BURST_10SEC);
   localparam logic [AW-1:0] LAST_REC = AW'(RECORDS - 1);

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Units of transmission between two bursts in the rate modes.
   function automatic logic [31:0] decade(input ins_e m);
      unique case (m)
         INS_R2:  decade = 32'h0000_0064;
         INS_R3:  decade = 32'h0000_03E8;
         INS_R4:  decade = 32'h0000_2710;
         INS_R5:  decade = 32'h0001_86A0;
         INS_R6:  decade = 32'h000F_4240;
         INS_R7:  decade = 32'h0098_9680;
         default: decade = 32'h0000_0001;
      endcase
   endfunction

   logic [31:0]        cfg;
   logic [BURST_W-1:0] burst;
   logic [23:0]        exp_sid;
   logic [23:0]        exp_did;
   logic [31:0]        frames;
   logic [31:0]        pat_err;
   logic [BURST_W-1:0] pending;
   logic               store_full;

   // Register decode.
   wire hit_ctrl  = wr && addr == CTRL_OFS;
   wire start     = hit_ctrl && wdata[CTL_START];
   wire stop      = hit_ctrl && wdata[CTL_STOP];
   wire trig      = hit_ctrl && wdata[CTL_TRIG];
   wire clear     = hit_ctrl && wdata[CTL_CLEAR];
   wire wr_cfg    = wr && addr == CONFIG_OFS;
   wire wr_burst  = wr && addr == BURST_OFS;
   wire wr_sid    = wr && addr == SID_OFS;
   wire wr_did    = wr && addr == DID_OFS;

   // Configuration fields.
   wire alarm_e alarm = alarm_e'(cfg[CF_ALARM +: 3]);
   wire err_e   etype = err_e'(cfg[CF_ERR +: 3]);
   wire ins_e   ins   = ins_e'(cfg[CF_INS +: 4]);
   wire rate_e  rate  = rate_e'(cfg[CF_RATE +: 2]);
   wire fast_rate     = rate == RATE_FC1200 || rate == RATE_FC1600;
   wire no_crc        = cfg[CF_NOCRC];

   // An error type the port cannot offer injects nothing at all.
   wire type_ok = (etype == ERR_SYM && !fast_rate)        // see [R9]
                  || (etype == ERR_CRC && !no_crc)        // see [R11]
                  || (etype == ERR_BLK && fast_rate)      // see [R12]
                  || etype == ERR_BIT || etype == ERR_RRDY;

   // Burst scheduling: the timer ticks on clocks or transmitted units.
   wire rate_mode = ins >= INS_R2;
   wire unit      = fast_rate ? blk_tick : gen_valid;
   wire tmr_tick  = rate_mode ? unit : 1'b1;
   wire [31:0] tmr_period = ins == INS_SEC   ? SEC_P     // see [R14]
                          : ins == INS_10SEC ? SEC10_P   // see [R15]
                          : decade(ins);                 // see [R16]
   wire periodic  = ins != INS_OFF && ins != INS_MAN;
   wire tmr_fire;

   burst_timer #(.WIDTH(32)) u_timer (
      .clk    (clk),
      .rst    (rst),
      .clr    (!periodic || wr_cfg || clear),
      .tick   (tmr_tick),
      .period (tmr_period),
      .fire   (tmr_fire)
   );

   wire fire = type_ok && ((ins == INS_MAN && trig)      // see [R13]
                           || (periodic && tmr_fire));

   // Where each error type may land in the word stream.
   wire slot = gen_valid && alarm == ALM_NONE;
   wire eligible = etype == ERR_BIT  ? slot && gen_payload   // see [R7]
                 : etype == ERR_CRC  ? slot && gen_crc       // see [R10]
                 : etype == ERR_RRDY ? slot && gen_idle      // see [R6]
                 : etype == ERR_SYM  ? slot                  // see [R8]
                 : etype == ERR_BLK  ? blk_tick              // see [R12]
                 : 1'b0;
   wire apply = pending != '0 && eligible && type_ok;

   // A new burst outranks the error being consumed in the same cycle.
   wire [BURST_W-1:0] next_pending =
        (ins == INS_OFF || clear) ? '0                      // see [R13]
      : fire  ? burst
      : apply ? pending - 1'b1
      : pending;

   // Alarm ordered set for the selected alarm, K28.5 leading.
   wire [31:0] alarm_word =
        alarm == ALM_LR  ? {K28_5, D9_2,  D31_5, D9_2}       // see [R2]
      : alarm == ALM_LRR ? {K28_5, D21_1, D31_5, D9_2}       // see [R3]
      : alarm == ALM_NOS ? {K28_5, D21_2, D31_5, D5_2}       // see [R4]
      :                    {K28_5, D21_1, D10_4, D21_2};     // see [R5]
   wire [31:0] rrdy_word = {K28_5, D21_4, D10_2, D10_2};

   // Next transmit word; alarms own every slot while selected.
   wire alarm_on = alarm != ALM_NONE;
   wire put_rrdy = apply && etype == ERR_RRDY;
   wire flip     = apply && (etype == ERR_BIT || etype == ERR_CRC);
   wire [31:0] next_tx_data = alarm_on ? alarm_word           // see [R1]
                            : put_rrdy ? rrdy_word            // see [R6]
                            : flip     ? gen_data ^ FLIP_BIT  // see [R7]
                            : gen_data;
   wire [3:0] next_tx_k = (alarm_on || put_rrdy) ? OSET_K : gen_k;

   // Receive qualification.
   filter_if fif ();
   assign fif.sid     = rx_sid;
   assign fif.did     = rx_did;
   assign fif.exp_sid = exp_sid;
   assign fif.exp_did = exp_did;
   assign fif.rctl    = rx_rctl;
   assign fif.ftype   = rx_ftype;
   assign fif.addr_en = cfg[CF_ADDR];

   frame_filter u_filter (
      .f (fif.filt)
   );

   wire [31:0] lost_add = (cfg[CF_LOST] && rx_lost)          // see [R17]
                          ? {16'h0000, rx_lost_bits} : 32'h0000_0000;
   wire [31:0] next_pat_err = pat_err + {24'h00_0000, rx_bit_errs}
                              + lost_add;

   // Results store: a write into the last record fills it.
   wire rec_wr    = store_wr && meas_run;
   wire fill      = rec_wr && store_addr == LAST_REC;
   wire cont      = cfg[CF_CONT];
   wire next_meas = start || (meas_run && !stop && !(fill && !cont));

   // Read multiplexer; unmapped offsets read as zero.
   wire [31:0] status = {28'h000_0000, pending != '0, gen_run,
                         store_full, meas_run};
   wire [31:0] next_rdata =
        addr == CONFIG_OFS ? cfg
      : addr == BURST_OFS  ? 32'(burst)
      : addr == SID_OFS    ? {8'h00, exp_sid}
      : addr == DID_OFS    ? {8'h00, exp_did}
      : addr == STATUS_OFS ? status
      : addr == FRAMES_OFS ? frames
      : addr == PATERR_OFS ? pat_err
      : addr == STADDR_OFS ? 32'(store_addr)
      : 32'h0000_0000;

   // Software registers; reset returns insertion to off.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfg     <= CONFIG_RST;                              // see [R23]
         burst   <= BURST_RST;
         exp_sid <= '0;
         exp_did <= '0;
      end
      else
      begin
         if (wr_cfg)
            cfg <= wdata;
         if (wr_burst)
            burst <= wdata[BURST_W-1:0];
         if (wr_sid)
            exp_sid <= wdata[23:0];
         if (wr_did)
            exp_did <= wdata[23:0];
      end
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata <= '0;
      else
         rdata <= rd ? next_rdata : 32'h0000_0000;
   end

   // Injection state and the registered transmit word.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pending     <= '0;                                  // see [R23]
         tx_valid    <= 1'b0;
         tx_data     <= '0;
         tx_k        <= '0;
         tx_code_bad <= 1'b0;
         tx_blk_bad  <= 1'b0;
      end
      else
      begin
         pending     <= next_pending;
         tx_valid    <= gen_valid;
         tx_data     <= next_tx_data;
         tx_k        <= next_tx_k;
         tx_code_bad <= apply && etype == ERR_SYM;           // see [R8]
         tx_blk_bad  <= apply && etype == ERR_BLK;           // see [R12]
      end
   end

   // Counters, measurement and store control; clear empties the counters and the store.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         frames     <= '0;                                   // see [R23]
         pat_err    <= '0;
         meas_run   <= 1'b0;
         store_addr <= '0;
         store_full <= 1'b0;
         log_full   <= 1'b0;
         gen_run    <= 1'b0;
      end
      else
      begin
         frames   <= clear ? '0 : frames + 32'(rx_frame && fif.hit);
         pat_err  <= clear ? '0 : next_pat_err;
         meas_run <= next_meas;                              // see [R21]
         gen_run  <= cfg[CF_AUTO] ? next_meas : cfg[CF_GENEN]; // see [R22]
         log_full <= fill && !store_full;                    // see [R21]
         if (clear || start)
         begin
            store_addr <= '0;
            store_full <= 1'b0;
         end
         else if (rec_wr)
         begin
            store_addr <= fill ? '0 : store_addr + 1'b1;
            store_full <= store_full || fill;
         end
      end
   end

   // Checks on the transmit side.
   alarm_word_a: assert property (                            // see [R1]
      alarm != ALM_NONE && !wr_cfg |=> tx_k == OSET_K
      && tx_data[31:24] == K28_5)
      else $error("alarm ordered set not sent");
   link_reset_a: assert property (                            // see [R2]
      alarm == ALM_LR |=> tx_data == {K28_5, D9_2, D31_5, D9_2})
      else $error("link reset set wrong");
   rrdy_emit_a: assert property (                             // see [R6]
      put_rrdy |=> tx_data == {K28_5, D21_4, D10_2, D10_2}
      ##0 tx_k == OSET_K)
      else $error("receiver ready set wrong");
   bit_flip_a: assert property (                              // see [R7]
      apply && etype == ERR_BIT |=>
      tx_data == ($past(gen_data) ^ FLIP_BIT))
      else $error("payload bit not inverted");
   sym_fast_a: assert property (                              // see [R9]
      fast_rate && etype == ERR_SYM |=> !tx_code_bad)
      else $error("symbol error at fast rate");
   off_quiet_a: assert property (                             // see [R13]
      ins == INS_OFF |=> pending == '0 ##1 !tx_code_bad && !tx_blk_bad)
      else $error("error injected while off");
   burst_load_a: assert property (                            // see [R13]
      fire && ins != INS_OFF && !clear |=> pending == $past(burst))
      else $error("burst length not loaded");
   // Checks on the receive and store side.
   lost_count_a: assert property (                            // see [R17]
      cfg[CF_LOST] && rx_lost && rx_bit_errs == 8'h00 && !clear |=>
      pat_err == $past(pat_err) + {16'h0000, $past(rx_lost_bits)})
      else $error("lost frame bits not counted");
   filter_strict_a: assert property (                         // see [R18]
      cfg[CF_ADDR] && rx_frame && rx_ftype != FILT_TYPE && !clear
      |=> frames == $past(frames))
      else $error("wrong type frame counted");
   store_stop_a: assert property (                            // see [R21]
      fill && !cont && !start |=> !meas_run ##0 log_full == !$past(store_full))
      else $error("full store did not stop");
   auto_gen_a: assert property (                              // see [R22]
      cfg[CF_AUTO] && !wr_cfg |=> gen_run == meas_run)
      else $error("generator not tied to measurement");
endmodule
`default_nettype wire

/* File: rtl/fc_stim_pkg.sv */
// Shared constants, register map and mode types of the stimulus injector.
`default_nettype none
package fc_stim_pkg;
   // Clock rate and the one-second burst period derived from it.
   localparam int CLK_HZ        = 40_000_000;
   localparam int BURST_SEC     = 1;
   localparam int BURST_10SEC   = 10;
   localparam int SEC_CYCLES    = CLK_HZ * BURST_SEC;
   // Results store size and the records it holds.
   localparam int STORE_MBYTES  = 64;
   localparam int RECORD_BYTES  = 4;
   localparam int STORE_RECORDS = STORE_MBYTES * 1024 * 1024 / RECORD_BYTES;
   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CONFIG_OFS = 8'h04;
   localparam logic [7:0] BURST_OFS  = 8'h08;
   localparam logic [7:0] SID_OFS    = 8'h0C;
   localparam logic [7:0] DID_OFS    = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   localparam logic [7:0] FRAMES_OFS = 8'h18;
   localparam logic [7:0] PATERR_OFS = 8'h1C;
   localparam logic [7:0] STADDR_OFS = 8'h20;
   // Control strobe bits.
   localparam int CTL_START = 0;
   localparam int CTL_STOP  = 1;
   localparam int CTL_TRIG  = 2;
   localparam int CTL_CLEAR = 3;
   // Configuration field positions.
   localparam int CF_ALARM  = 0;
   localparam int CF_ERR    = 3;
   localparam int CF_INS    = 6;
   localparam int CF_LOST   = 10;
   localparam int CF_ADDR   = 11;
   localparam int CF_CONT   = 12;
   localparam int CF_AUTO   = 13;
   localparam int CF_GENEN  = 14;
   localparam int CF_RATE   = 15;
   localparam int CF_NOCRC  = 17;
   localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
   localparam logic [15:0] BURST_RST  = 16'h0001;
   // Code group bytes, written as D/Kx.y = {y, x}.
   localparam logic [7:0] K28_5 = 8'hBC;
   localparam logic [7:0] D9_2  = 8'h49;
   localparam logic [7:0] D31_5 = 8'hBF;
   localparam logic [7:0] D21_1 = 8'h35;
   localparam logic [7:0] D21_2 = 8'h55;
   localparam logic [7:0] D5_2  = 8'h45;
   localparam logic [7:0] D10_4 = 8'h8A;
   localparam logic [7:0] D21_4 = 8'h95;
   localparam logic [7:0] D10_2 = 8'h4A;
   localparam logic [3:0] OSET_K = 4'h8;
   localparam logic [7:0] FILT_RCTL = 8'h00;
   localparam logic [7:0] FILT_TYPE = 8'hE0;
   localparam logic [31:0] FLIP_BIT = 32'h0000_0001;
   typedef enum logic [2:0] {ALM_NONE, ALM_LR, ALM_LRR, ALM_NOS, ALM_OLS}
      alarm_e;
   typedef enum logic [2:0] {ERR_NONE, ERR_BIT, ERR_SYM, ERR_RRDY, ERR_CRC,
      ERR_BLK} err_e;
   typedef enum logic [3:0] {INS_OFF, INS_MAN, INS_SEC, INS_10SEC, INS_R2,
      INS_R3, INS_R4, INS_R5, INS_R6, INS_R7} ins_e;
   typedef enum logic [1:0] {RATE_8B10B, RATE_FC1200, RATE_FC1600} rate_e;
endpackage
`default_nettype wire

/* File: rtl/filter_if.sv */
// Frame header fields and match result passed to the receive frame filter.
`default_nettype none
interface filter_if;
   logic [23:0] sid;
   logic [23:0] did;
   logic [23:0] exp_sid;
   logic [23:0] exp_did;
   logic [7:0]  rctl;
   logic [7:0]  ftype;
   logic        addr_en;
   logic        hit;
   modport filt (input sid, did, exp_sid, exp_did, rctl, ftype, addr_en,
                 output hit);
   modport user (output sid, did, exp_sid, exp_did, rctl, ftype, addr_en,
                 input hit);
endinterface
`default_nettype wire

/* File: rtl/frame_filter.sv */
// Receive frame filter deciding whether a frame counts in the results.
`default_nettype none
module frame_filter
   import fc_stim_pkg::*;
(
   filter_if.filt f   // Header fields in, match out.
);
   // Strict match also checks both addresses and the vendor type.
   wire strict_hit = f.sid == f.exp_sid && f.did == f.exp_did
                     && f.rctl == FILT_RCTL && f.ftype == FILT_TYPE;
   // Loose match only asks for device data routing.
   wire loose_hit = f.rctl == FILT_RCTL;
   assign f.hit = f.addr_en ? strict_hit : loose_hit; // see [R18] see [R19]
endmodule
`default_nettype wire

/* File: rtl/burst_timer.sv */
// Programmable period counter that fires once per period of ticks.
`default_nettype none
module burst_timer #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk,     // System clock.
   input  wire logic             rst,     // Asynchronous reset.
   input  wire logic             clr,     // Restart the period.
   input  wire logic             tick,    // One unit of elapsed time.
   input  wire logic [WIDTH-1:0] period,  // Ticks per period.
   output logic                  fire     // Period end pulse.
);
   logic [WIDTH-1:0] count;
   wire last = count >= period - 1'b1;
   assign fire = tick && last && !clr;
   // Restarting on any clear keeps a mode change from firing early.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         count <= '0;
      else if (clr || fire)
         count <= '0;
      else if (tick)
         count <= count + 1'b1;
   end
endmodule
`default_nettype wire

/* File: test/fc_far_end.sv */
// Far-end device model that presents received frame headers and losses.
`default_nettype none
module fc_far_end (
   input  wire logic        clk,       // Word clock.
   output logic             frame,     // Header strobe.
   output logic [23:0]      sid,       // Source ID.
   output logic [23:0]      did,       // Destination ID.
   output logic [7:0]       rctl,      // Routing control.
   output logic [7:0]       ftype,     // Type field.
   output logic [7:0]       bit_errs,  // Bit errors this word.
   output logic             lost,      // Frame missed.
   output logic [15:0]      lost_bits  // Its pattern bits.
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle fields hold a pattern rather than the last header.
   initial
   begin
      {frame, lost, bit_errs} = '0;
      {sid, did, rctl, ftype, lost_bits} = '1;
   end

   // Header fields last one word, then show their inverse.
   task automatic send(input logic [23:0] s, d, input logic [7:0] r, t);
      @(posedge clk);
      {sid, did, rctl, ftype} <= {s, d, r, t};
      frame <= 1'b1;
      @(posedge clk);
      {sid, did, rctl, ftype} <= ~{s, d, r, t};
      frame <= 1'b0;
   endtask

   // Frame sizes are whole words, so lost bits are multiples of 32.
   task automatic lose(input logic [15:0] bytes, input logic [7:0] e);
      @(posedge clk);
      lost_bits <= {bytes[12:2], 5'h00};
      lost <= 1'b1;
      bit_errs <= e;
      @(posedge clk);
      lost_bits <= ~{bytes[12:2], 5'h00};
      lost <= 1'b0;
      bit_errs <= 8'h00;
   endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the stimulus injector.
`default_nettype none
module testbench;
   import fc_stim_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] WD = 32'h1234_5678;
   typedef struct {logic [31:0] cfg; int n; logic [31:0] hit;} row_s;
   logic        clk, rst, wr, rd, slot, store_wr, frame, lost;
   logic [7:0]  addr, rctl, ftype, bit_errs;
   logic [31:0] wdata, rdata, tx_data;
   logic [23:0] sid, did;
   logic [15:0] lost_bits;
   int          fail_count = 0;
   int          checks_done = 0;
   // Configuration, slots expected to change, and the changed word.
   row_s rows [9] = '{
      '{32'h1, 3, 32'hBC49_BF49},       // Link reset
      '{32'h2, 3, 32'hBC35_BF49},       // Reset response
      '{32'h3, 3, 32'hBC55_BF45},       // Not operational
      '{32'h4, 3, 32'hBC35_8A55},       // Offline
      '{32'h48, 2, WD ^ 32'h1},         // Manual bit burst
      '{32'h08, 0, WD},                 // Off mode
      '{32'h60, 2, WD ^ 32'h1},         // Manual CRC burst
      '{32'h2_0060, 0, WD},             // No CRC field
      '{32'h58, 2, 32'hBC95_4A4A}};     // Receiver ready

   fc_stim_inject #(.SEC_CLKS(50), .RECORDS(16)) u_fc_stim_inject (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .gen_valid(1'b1), .gen_data(WD), .gen_k(4'h0),
      .gen_payload(slot), .gen_crc(slot), .gen_idle(slot),
      .blk_tick(1'b0), .tx_valid(), .tx_data(tx_data), .tx_k(),
      .tx_code_bad(), .tx_blk_bad(), .gen_run(), .rx_frame(frame),
      .rx_sid(sid), .rx_did(did), .rx_rctl(rctl), .rx_ftype(ftype),
      .rx_bit_errs(bit_errs), .rx_lost(lost), .rx_lost_bits(lost_bits),
      .store_wr(store_wr), .store_addr(), .meas_run(), .log_full());

   fc_far_end u_fc_far_end (
      .clk(clk), .frame(frame), .sid(sid), .did(did), .rctl(rctl),
      .ftype(ftype), .bit_errs(bit_errs), .lost(lost),
      .lost_bits(lost_bits));

   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   // One trigger, then four eligible slots back to back, the first three checked.
   task automatic inj(input row_s r);
      bus_wr(CONFIG_OFS, r.cfg);
      bus_wr(CTRL_OFS, 32'h4);
      @(posedge clk);
      slot <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         #1 chk(tx_data, i < r.n ? r.hit : WD);
      end
      @(posedge clk);
      slot <= 1'b0;
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // The whole run needs well under a thousand cycles.
   initial
   begin
      #(25 * 5000);
      fail_count++;
      final_report();
   end

   initial
   begin
      {rst, wr, rd, slot, store_wr} = 5'b10000;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus_rd(CONFIG_OFS, 32'h0);
      bus_rd(BURST_OFS, 32'h1);
      bus_rd(STATUS_OFS, 32'h0);
      bus_rd(8'h40, 32'h0);
      $display("test reset done");
      bus_wr(BURST_OFS, 32'h2);
      foreach (rows[i])
         inj(rows[i]);
      $display("test injection done");
      bus_wr(SID_OFS, 32'h01_0203);
      bus_wr(DID_OFS, 32'h04_0506);
      bus_wr(CONFIG_OFS, 32'h800);
      u_fc_far_end.send(24'h01_0203, 24'h04_0506, 8'h00, 8'hE0);
      u_fc_far_end.send(24'h01_0204, 24'h04_0506, 8'h00, 8'hE0);
      u_fc_far_end.send(24'h01_0203, 24'h04_0506, 8'h00, 8'hE1);
      bus_rd(FRAMES_OFS, 32'h1);
      bus_wr(CONFIG_OFS, 32'h0);
      u_fc_far_end.send(24'h00_0000, 24'h00_0000, 8'h00, 8'h00);
      u_fc_far_end.send(24'h00_0000, 24'h00_0000, 8'h01, 8'h00);
      bus_rd(FRAMES_OFS, 32'h2);
      $display("test filter done");
      bus_wr(CONFIG_OFS, 32'h400);
      u_fc_far_end.lose(16'd12, 8'd3);
      bus_wr(CONFIG_OFS, 32'h0);
      u_fc_far_end.lose(16'd12, 8'd3);
      bus_rd(PATERR_OFS, 32'd102);
      bus_wr(CTRL_OFS, 32'h8);
      bus_rd(PATERR_OFS, 32'h0);
      bus_rd(FRAMES_OFS, 32'h0);
      $display("test lost frames done");
      bus_wr(CONFIG_OFS, 32'h2000);
      bus_wr(CTRL_OFS, 32'h1);
      bus_rd(STATUS_OFS, 32'h5);
      repeat (16)
      begin
         @(posedge clk);
         store_wr <= 1'b1;
      end
      @(posedge clk);
      store_wr <= 1'b0;
      repeat (2) @(posedge clk);
      bus_rd(STATUS_OFS, 32'h2);
      bus_rd(STADDR_OFS, 32'h0);
      $display("test store done");
      final_report();
   end
endmodule
`default_nettype wire
